//--- rtl/uart_pkg.sv
// Register map, field positions, reset values and state types of the serial control block
package uart_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_FRAME  = 12'h000;
  localparam logic [11:0] OFS_ENABLE = 12'h004;
  localparam logic [11:0] OFS_NINTH  = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00C;
  localparam logic [11:0] OFS_DATA   = 12'h010;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int F_UNIT_ON = 6, F_TX_INV = 5, F_CHAR9 = 4, F_ROUSE = 3;
  localparam int F_IDLE_ORG = 2, F_PAR_ON = 1, F_PAR_ODD = 0;
  localparam int F_TBE_IE = 7, F_DONE_IE = 6, F_FULL_IE = 5, F_IDLE_IE = 4;
  localparam int F_TX_ON = 3, F_RX_ON = 2, F_STANDBY = 1, F_BREAK = 0;
  localparam int F_RX9 = 7, F_TX9 = 6, F_OR_IE = 3, F_NF_IE = 2, F_FE_IE = 1, F_PE_IE = 0;
  localparam int F_TBE = 7, F_DONE = 6, F_FULL = 5, F_QUIET = 4;
  localparam int F_OR = 3, F_NF = 2, F_FE = 1, F_PE = 0;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CTRL     = 8'h00;
  localparam logic [7:0] RST_STATUS   = 8'hC0;
  localparam int         BIT_CYCLES_DEF = 16;
  localparam logic [3:0] LEN8_BITS    = 4'hA;
  localparam logic [3:0] LEN9_BITS    = 4'hB;

  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_BRK} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_t;

endpackage : uart_pkg

//--- rtl/uart_ctrl_status_logic.sv
// Control, status and serial engine of the asynchronous transceiver with APB access
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module uart_ctrl_status_logic import uart_pkg::*; #(
  parameter int BIT_CYCLES = BIT_CYCLES_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        rx_pin_i,
  output logic             tx_pin_o,
  output logic             tx_irq_o,
  output logic             rx_irq_o,
  output logic             err_irq_o
);

  localparam int TW = $clog2(BIT_CYCLES + 1);
  localparam logic [TW-1:0] BIT_LAST  = TW'(BIT_CYCLES - 1);
  localparam logic [TW-1:0] HALF_LAST = TW'(BIT_CYCLES / 2 - 1);

  logic unit_on, tx_invert, char_len_sel, rouse_source_sel, idle_count_origin;
  logic parity_on, parity_odd_sel;
  logic tx_empty_irq_en, tx_done_irq_en, rx_full_irq_en, idle_irq_en;
  logic tx_on, rx_on, rx_standby, break_send;
  logic overrun_irq_en, noise_irq_en, framing_irq_en, parity_err_irq_en;
  logic rx_ninth_bit, tx_ninth_bit;
  logic [7:0] tx_data, rx_data, stat_seen, status_val;
  logic tx_buf_empty, tx_done, rx_buf_full, line_quiet_flag;
  logic overrun_flag, noise_flag, framing_flag, parity_err_flag;
  logic tx_on_d, rx_on_d, pre_pend, idle_armed, rx_d, rx_noisy, quiet_full_d;
  tx_state_t  tx_st;
  rx_state_t  rx_st;
  logic [10:0] tx_shift, rx_shift, frame, rx_full;
  logic [3:0]  tx_bits, rx_cnt, quiet_cnt, nbits;
  logic [TW-1:0] tx_tick, rx_tick, quiet_tick;
  logic [31:0] rd_val;
  logic        rd_err;

  // ----------------------------------------------------------------
  // APB access
  // ----------------------------------------------------------------
  logic acc, wr, rd;
  logic hit_frame, hit_enable, hit_ninth, hit_status, hit_data;
  assign acc        = psel_i & penable_i & pready_o;
  assign wr         = acc & pwrite_i;
  assign rd         = acc & ~pwrite_i;
  assign hit_frame  = paddr_i == OFS_FRAME;
  assign hit_enable = paddr_i == OFS_ENABLE;
  assign hit_ninth  = paddr_i == OFS_NINTH;
  assign hit_status = paddr_i == OFS_STATUS;
  assign hit_data   = paddr_i == OFS_DATA;

  assign status_val = {tx_buf_empty, tx_done, rx_buf_full, line_quiet_flag,
                       overrun_flag, noise_flag, framing_flag, parity_err_flag};

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    if (hit_frame) begin
      rd_val[7:0] = {1'b0, unit_on, tx_invert, char_len_sel, rouse_source_sel,
                     idle_count_origin, parity_on, parity_odd_sel};
    end else if (hit_enable) begin
      rd_val[7:0] = {tx_empty_irq_en, tx_done_irq_en, rx_full_irq_en, idle_irq_en,
                     tx_on, rx_on, rx_standby, break_send};
    end else if (hit_ninth) begin
      rd_val[7:0] = {rx_ninth_bit, tx_ninth_bit, 2'b00, overrun_irq_en, noise_irq_en,
                     framing_irq_en, parity_err_irq_en};
    end else if (hit_status) begin
      rd_val[7:0] = status_val;
    end else if (hit_data) begin
      rd_val[7:0] = rx_data;
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & rd_err;
      if (psel_i && !penable_i) begin
        prdata_o <= pwrite_i ? 32'h0000_0000 : rd_val;
      end
    end
  end

  // Status read arms the clear done by the following data access
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stat_seen <= 8'h00;
    end else if (rd && hit_status) begin
      stat_seen <= prdata_o[7:0];
    end else if (acc && hit_data) begin
      stat_seen <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic rx_done, idle_hit, wake;
  assign wake = rx_standby & ((rx_done & rouse_source_sel & rx_full[9])
              | (idle_hit & ~rouse_source_sel));

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {unit_on, tx_invert, char_len_sel, rouse_source_sel} <= RST_CTRL[3:0];
      {idle_count_origin, parity_on, parity_odd_sel} <= RST_CTRL[2:0];
      {tx_empty_irq_en, tx_done_irq_en, rx_full_irq_en, idle_irq_en} <= RST_CTRL[3:0];
      {tx_on, rx_on, rx_standby, break_send} <= RST_CTRL[3:0];
      {overrun_irq_en, noise_irq_en, framing_irq_en, parity_err_irq_en} <= RST_CTRL[3:0];
    end else begin
      if (wake) begin
        rx_standby <= 1'b0;
      end
      if (wr && hit_frame) begin
        unit_on           <= pwdata_i[F_UNIT_ON];
        tx_invert         <= pwdata_i[F_TX_INV];
        char_len_sel      <= pwdata_i[F_CHAR9];
        rouse_source_sel  <= pwdata_i[F_ROUSE];
        idle_count_origin <= pwdata_i[F_IDLE_ORG];
        parity_on         <= pwdata_i[F_PAR_ON];
        parity_odd_sel    <= pwdata_i[F_PAR_ODD];
      end else if (wr && hit_enable) begin
        tx_empty_irq_en <= pwdata_i[F_TBE_IE];
        tx_done_irq_en  <= pwdata_i[F_DONE_IE];
        rx_full_irq_en  <= pwdata_i[F_FULL_IE];
        idle_irq_en     <= pwdata_i[F_IDLE_IE];
        rx_standby      <= pwdata_i[F_STANDBY];
        break_send      <= pwdata_i[F_BREAK];
        if (unit_on) begin
          tx_on <= pwdata_i[F_TX_ON];
          rx_on <= pwdata_i[F_RX_ON];
        end
      end else if (wr && hit_ninth) begin
        overrun_irq_en    <= pwdata_i[F_OR_IE];
        noise_irq_en      <= pwdata_i[F_NF_IE];
        framing_irq_en    <= pwdata_i[F_FE_IE];
        parity_err_irq_en <= pwdata_i[F_PE_IE];
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  logic tx_par, tx_b7, tx_b8, tx_load, tx_line;
  assign nbits   = char_len_sel ? LEN9_BITS : LEN8_BITS;
  assign tx_par  = parity_odd_sel ^ (char_len_sel ? ^tx_data : ^tx_data[6:0]);
  assign tx_b7   = (parity_on && !char_len_sel) ? tx_par : tx_data[7];
  assign tx_b8   = parity_on ? tx_par : tx_ninth_bit;
  assign frame   = {1'b1, char_len_sel ? tx_b8 : 1'b1, tx_b7, tx_data[6:0], 1'b0};
  assign tx_load = unit_on && tx_st == TX_IDLE && tx_on && !break_send && !pre_pend
                   && !tx_buf_empty;
  assign tx_line = (tx_st == TX_IDLE) ? 1'b1 : tx_shift[0];

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_on_d  <= 1'b0;
      pre_pend <= 1'b0;
    end else begin
      tx_on_d <= tx_on;
      if (!unit_on || (tx_st == TX_IDLE && tx_on && (break_send || pre_pend))) begin
        pre_pend <= 1'b0;
      end
      if (unit_on && tx_on && !tx_on_d) begin
        pre_pend <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_st    <= TX_IDLE;
      tx_shift <= 11'h7FF;
      tx_bits  <= 4'h0;
      tx_tick  <= '0;
    end else if (!unit_on) begin
      tx_st <= TX_IDLE;
    end else begin
      case (tx_st)
        TX_IDLE: begin
          tx_tick <= '0;
          tx_bits <= nbits;
          if (tx_on && break_send) begin
            tx_st    <= TX_BRK;
            tx_shift <= 11'h000;
          end else if (tx_on && pre_pend) begin
            tx_st    <= TX_SEND;
            tx_shift <= 11'h7FF;
          end else if (tx_load) begin
            tx_st    <= TX_SEND;
            tx_shift <= frame;
          end
        end
        default: begin
          if (tx_tick == BIT_LAST) begin
            tx_tick  <= '0;
            tx_shift <= {tx_st != TX_BRK, tx_shift[10:1]};
            tx_bits  <= tx_bits - 4'h1;
            if (tx_bits == 4'h1) begin
              if (tx_st == TX_BRK && break_send) begin
                tx_shift <= 11'h000;
                tx_bits  <= nbits;
              end else if (tx_st == TX_BRK) begin
                tx_st    <= TX_SEND;
                tx_shift <= 11'h7FF;
                tx_bits  <= 4'h1;
              end else begin
                tx_st <= TX_IDLE;
              end
            end
          end else begin
            tx_tick <= tx_tick + 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  logic rx_en, rx_samp, rx_commit, commit_ok, par_bad;
  assign rx_en     = unit_on & rx_on;
  assign rx_samp   = rx_st == RX_BITS && rx_tick == BIT_LAST;
  assign rx_done   = rx_samp && rx_cnt == nbits - 4'h2;
  assign rx_full   = {rx_pin_i, rx_shift[10:1]};
  assign rx_commit = rx_done & (~rx_standby | (rouse_source_sel & rx_full[9]));
  assign commit_ok = rx_commit & ~rx_buf_full;
  assign par_bad   = parity_on & ((char_len_sel ? ^rx_full[9:1] : ^rx_full[9:2])
                     != parity_odd_sel);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_st    <= RX_IDLE;
      rx_shift <= 11'h000;
      rx_cnt   <= 4'h0;
      rx_tick  <= '0;
      rx_d     <= 1'b1;
      rx_noisy <= 1'b0;
    end else begin
      rx_d <= rx_pin_i;
      if (!rx_en) begin
        rx_st <= RX_IDLE;
      end else begin
        case (rx_st)
          RX_IDLE: begin
            rx_tick  <= '0;
            rx_cnt   <= 4'h0;
            rx_noisy <= 1'b0;
            if (!rx_pin_i) begin
              rx_st <= RX_START;
            end
          end
          RX_START: begin
            if (rx_tick == HALF_LAST) begin
              rx_tick <= '0;
              rx_st   <= rx_pin_i ? RX_IDLE : RX_BITS;
            end else begin
              rx_tick <= rx_tick + 1'b1;
            end
          end
          default: begin
            if (rx_samp) begin
              rx_tick  <= '0;
              rx_shift <= rx_full;
              rx_cnt   <= rx_cnt + 4'h1;
              rx_noisy <= rx_noisy | (rx_pin_i ^ rx_d);
              if (rx_done) begin
                rx_st <= RX_IDLE;
              end
            end else begin
              rx_tick <= rx_tick + 1'b1;
            end
          end
        endcase
      end
    end
  end

  // Counts bit times of consecutive ones for idle detection
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      quiet_cnt    <= 4'h0;
      quiet_tick   <= '0;
      quiet_full_d <= 1'b0;
    end else begin
      quiet_full_d <= quiet_cnt == nbits;
      if (!rx_en || !rx_pin_i) begin
        quiet_cnt  <= 4'h0;
        quiet_tick <= '0;
      end else if (rx_samp) begin
        quiet_tick <= '0;
        if (idle_count_origin || quiet_cnt == nbits) begin
          quiet_cnt <= idle_count_origin ? 4'h0 : quiet_cnt;
        end else begin
          quiet_cnt <= quiet_cnt + 4'h1;
        end
      end else if (rx_st == RX_IDLE) begin
        if (quiet_tick == BIT_LAST) begin
          quiet_tick <= '0;
          if (quiet_cnt != nbits) begin
            quiet_cnt <= quiet_cnt + 4'h1;
          end
        end else begin
          quiet_tick <= quiet_tick + 1'b1;
        end
      end
    end
  end
  assign idle_hit = quiet_cnt == nbits && !quiet_full_d;

  // ----------------------------------------------------------------
  // Status flags; a set in the clearing cycle wins
  // ----------------------------------------------------------------
  logic data_rd, data_wr;
  assign data_rd = rd & hit_data;
  assign data_wr = wr & hit_data;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {tx_buf_empty, tx_done, rx_buf_full, line_quiet_flag} <= RST_STATUS[7:4];
      {overrun_flag, noise_flag, framing_flag, parity_err_flag} <= RST_STATUS[3:0];
      {idle_armed, rx_on_d} <= 2'b00;
    end else begin
      rx_on_d <= rx_on;
      if (data_wr && stat_seen[F_TBE]) begin
        tx_buf_empty <= 1'b0;
      end
      if (tx_load || !unit_on) begin
        tx_buf_empty <= 1'b1;
      end
      tx_done <= !unit_on || (tx_buf_empty && tx_st == TX_IDLE
                 && !(tx_on && (pre_pend || break_send)) && !tx_load);
      if (data_rd) begin
        rx_buf_full     <= rx_buf_full & ~stat_seen[F_FULL];
        line_quiet_flag <= line_quiet_flag & ~stat_seen[F_QUIET];
        overrun_flag    <= overrun_flag & ~stat_seen[F_OR];
        noise_flag      <= noise_flag & ~stat_seen[F_NF];
        framing_flag    <= framing_flag & ~stat_seen[F_FE];
        parity_err_flag <= parity_err_flag & ~stat_seen[F_PE];
      end
      if ((rx_on && !rx_on_d) || (data_rd && stat_seen[F_QUIET])) begin
        idle_armed <= 1'b0;
      end
      if (commit_ok) begin
        rx_buf_full <= 1'b1;
        idle_armed  <= 1'b1;
        if (!rx_full[10]) framing_flag <= 1'b1;
        if (par_bad) parity_err_flag <= 1'b1;
        if (rx_noisy || (rx_pin_i ^ rx_d)) noise_flag <= 1'b1;
      end
      if (rx_commit && rx_buf_full) begin
        overrun_flag <= 1'b1;
      end
      if (idle_hit && idle_armed && !rx_standby) begin
        line_quiet_flag <= 1'b1;
      end
    end
  end

  // Data buffer and ninth bits keep their contents through reset
  always_ff @(posedge clk_i) begin
    if (data_wr) begin
      tx_data <= pwdata_i[7:0];
    end
    if (wr && hit_ninth) begin
      tx_ninth_bit <= pwdata_i[F_TX9];
    end
    if (commit_ok) begin
      rx_data      <= char_len_sel ? rx_full[8:1] : rx_full[9:2];
      rx_ninth_bit <= rx_full[9];
    end
  end

  // ----------------------------------------------------------------
  // Pin and interrupt outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_pin_o  <= 1'b1;
      tx_irq_o  <= 1'b0;
      rx_irq_o  <= 1'b0;
      err_irq_o <= 1'b0;
    end else begin
      tx_pin_o  <= tx_invert ^ tx_line;
      tx_irq_o  <= unit_on & ((tx_buf_empty & tx_empty_irq_en)
                 | (tx_done & tx_done_irq_en));
      rx_irq_o  <= ~rx_standby & ((rx_buf_full & rx_full_irq_en)
                 | (line_quiet_flag & idle_irq_en));
      err_irq_o <= (overrun_flag & overrun_irq_en) | (noise_flag & noise_irq_en)
                 | (framing_flag & framing_irq_en) | (parity_err_flag & parity_err_irq_en);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_full_seen;
    rd && hit_status && prdata_o[F_FULL];
  endsequence
  sequence s_data_take;
    data_rd && !commit_ok && stat_seen[F_FULL];
  endsequence

  a_idle_pin_level: assert property ((tx_st == TX_IDLE) |=> tx_pin_o == !$past(tx_invert))
    else $error("idle tx level not inverted correctly");
  a_break_low: assert property ((tx_st == TX_BRK) |=> tx_pin_o == $past(tx_invert))
    else $error("break bit not low on line");
  a_load_empty: assert property (tx_load |=> tx_buf_empty && tx_st == TX_SEND)
    else $error("load did not set empty flag");
  a_load_busy: assert property (tx_load |-> ##2 !tx_done)
    else $error("done still set after load");
  a_unit_off: assert property (!unit_on |=> tx_buf_empty && !tx_irq_o)
    else $error("unit off did not force empty");
  a_standby_mask: assert property (rx_standby |=> !rx_irq_o)
    else $error("receiver interrupt during standby");
  a_err_raise: assert property ((overrun_flag && overrun_irq_en) |=> err_irq_o)
    else $error("error interrupt missing");
  a_quiet_armed: assert property ($rose(line_quiet_flag) |-> $past(idle_armed))
    else $error("quiet flag set without prior character");
  a_addr_wake: assert property ((rx_done && rx_standby && rouse_source_sel && rx_full[9]
    && !rx_buf_full) |=> !rx_standby && rx_buf_full)
    else $error("address mark did not wake");
  a_full_clear: assert property (s_full_seen ##[1:8] s_data_take |=> !rx_buf_full)
    else $error("full flag not cleared by sequence");

endmodule : uart_ctrl_status_logic
`default_nettype wire

//--- testbench/uart_remote_node.sv
// Remote serial node: drives the receive line, samples the transmit line
`timescale 1ns/1ns
`default_nettype none
module uart_remote_node #(
  parameter int BIT = 4
) (
  input  wire logic clk_i,
  input  wire logic tx_line_i,
  output var  logic rx_line_o
);
  initial rx_line_o = 1'b1;
  // Start bit, data LSB first, stop level, then idle high
  task automatic send(input logic [8:0] d, input int n, input logic stop);
    for (int i = 0; i < n + 2; i++) begin
      rx_line_o <= (i == 0) ? 1'b0 : (i > n) ? stop : d[i-1];
      repeat (BIT) @(posedge clk_i);
    end
    rx_line_o <= 1'b1;
  endtask : send
  // Waits for a start bit, then samples mid-bit
  task automatic grab(input int n, output logic [10:0] f);
    f = '0;
    while (tx_line_i !== 1'b0) @(posedge clk_i);
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      f[i] = tx_line_i;
      repeat (BIT) @(posedge clk_i);
    end
  endtask : grab
endmodule : uart_remote_node
`default_nettype wire

//--- testbench/uart_ctrl_status_logic_tb_top.sv
// Self-checking bench of the serial control block
`timescale 1ns/1ns
`default_nettype none
module uart_ctrl_status_logic_tb_top;
  import uart_pkg::*;
  localparam int BIT = 4;
  logic clk_i, nrst_i, psel, penable, pwrite, pready, pslverr, e;
  logic rx_line, tx_pin, tx_irq, rx_irq, err_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [31:0] seed = 32'h0000000C;
  logic [10:0] f;
  logic [7:0]  b;
  int failures = 0;
  int tests_run = 0;
  uart_ctrl_status_logic #(.BIT_CYCLES(BIT)) u_dut (.clk_i(clk_i), .nrst_i(nrst_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .rx_pin_i(rx_line), .tx_pin_o(tx_pin), .tx_irq_o(tx_irq), .rx_irq_o(rx_irq),
    .err_irq_o(err_irq));
  uart_remote_node #(.BIT(BIT)) u_peer (.clk_i(clk_i), .tx_line_i(tx_pin), .rx_line_o(rx_line));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [31:0] exp_frame(input logic [7:0] d);
    return {22'h0, 1'b1, d, 1'b0};
  endfunction : exp_frame
  // Nine-bit frame whose top data bit carries odd parity
  function automatic logic [31:0] exp_par9(input logic [7:0] d);
    return {21'h0, 1'b1, ~^d, d, 1'b0};
  endfunction : exp_par9
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) begin
      @(posedge clk_i);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask : apb
  initial begin
    nrst_i = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(q, 32'h000000C0);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, OFS_ENABLE, 32'h0000000C);
    apb(1'b0, OFS_ENABLE, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, OFS_FRAME, 32'h00000040);
    apb(1'b1, OFS_ENABLE, 32'h000000AC);
    repeat (2) @(posedge clk_i);
    chk({31'h0, tx_irq}, 32'h1);
    q = xs();
    b = q[7:0];
    apb(1'b0, OFS_STATUS, 32'h0);
    fork
      apb(1'b1, OFS_DATA, {24'h0, b});
      u_peer.grab(10, f);
    join
    chk({21'h0, f}, exp_frame(b));
    for (int k = 0; k < 3; k++) begin
      q = xs();
      // Top bit low keeps trailing ones short of an idle frame
      b = (k == 0) ? 8'hFF : (q[7:0] & 8'h7F);
      u_peer.send({1'b0, b}, 8, 1'b1);
      repeat (BIT) @(posedge clk_i);
      chk({31'h0, rx_irq}, 32'h1);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(q & 32'h20, 32'h20);
      apb(1'b0, OFS_DATA, 32'h0);
      chk(q, {24'h0, b});
      apb(1'b0, OFS_NINTH, 32'h0);
      chk(q & 32'h80, {24'h0, b[7], 7'h0});
      repeat (2) @(posedge clk_i);
      chk({31'h0, rx_irq}, 32'h0);
    end
    repeat (14 * BIT) @(posedge clk_i);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(q & 32'h10, 32'h10);
    apb(1'b0, OFS_DATA, 32'h0);
    repeat (14 * BIT) @(posedge clk_i);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(q & 32'h10, 32'h0);
    apb(1'b1, OFS_NINTH, 32'h00000002);
    u_peer.send(9'h055, 8, 1'b0);
    repeat (BIT) @(posedge clk_i);
    chk({31'h0, err_irq}, 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    apb(1'b0, OFS_DATA, 32'h0);
    chk(q, 32'h00000055);
    // Standby with address mark wake
    apb(1'b1, OFS_FRAME, 32'h00000048);
    apb(1'b1, OFS_ENABLE, 32'h0000002E);
    u_peer.send(9'h012, 8, 1'b1);
    repeat (BIT) @(posedge clk_i);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(q & 32'h20, 32'h0);
    u_peer.send(9'h0A5, 8, 1'b1);
    repeat (BIT) @(posedge clk_i);
    chk({31'h0, rx_irq}, 32'h1);
    apb(1'b0, OFS_ENABLE, 32'h0);
    chk(q & 32'h02, 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(q & 32'h20, 32'h20);
    apb(1'b0, OFS_DATA, 32'h0);
    chk(q, 32'h000000A5);
    // Nine-bit characters with odd parity
    apb(1'b1, OFS_FRAME, 32'h00000053);
    apb(1'b0, OFS_STATUS, 32'h0);
    q = xs();
    b = q[7:0];
    fork
      apb(1'b1, OFS_DATA, {24'h0, b});
      u_peer.grab(11, f);
    join
    chk({21'h0, f}, exp_par9(b));
    // Held break, then release
    apb(1'b1, OFS_ENABLE, 32'h0000000D);
    u_peer.grab(11, f);
    chk({21'h0, f}, 32'h0);
    apb(1'b1, OFS_ENABLE, 32'h0000008C);
    repeat (12 * BIT) @(posedge clk_i);
    chk({31'h0, tx_pin}, 32'h1);
    apb(1'b1, OFS_FRAME, 32'h00000060);
    repeat (2) @(posedge clk_i);
    chk({31'h0, tx_pin}, 32'h0);
    apb(1'b1, OFS_FRAME, 32'h0);
    repeat (2) @(posedge clk_i);
    chk({31'h0, tx_irq}, 32'h0);
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    stop_test();
  end
endmodule : uart_ctrl_status_logic_tb_top
`default_nettype wire
